//--- rtl/link_timing_pkg.sv
// constants and types shared by the rs485 link timing control block
// Contract
// - rate code 02 loopback, 03..06 rates
// - station number 1 to 32, default 1
// - protocol 00 char, 01 binary; width ignored
// - loopback code at startup runs self-test, reports
// - response waits silent interval plus wait
// - silent interval is 3.5 characters at rate
// - response wait 0 to 1000 ms, added
// - timeout after response flags comm error
// - timeout 0.00 disables, 0.01 to 99.99 s
// - on timeout act, then await new query
// - monitor idle until first completed exchange
// - action 00 trips, 01 decelerates then trips; code raises decel_stop and trip in the same cycle
// - actions 02/03/04 never trip or alarm; code still pulses comm_error for them
// - short gap query gets no response
package link_timing_pkg;
   localparam int          CLK_HZ         = 125_000_000;
   // line rate codes
   localparam logic [3:0]  RATE_LOOPBACK  = 4'h2;
   localparam logic [3:0]  RATE_2400      = 4'h3;
   localparam logic [3:0]  RATE_4800      = 4'h4;
   localparam logic [3:0]  RATE_9600      = 4'h5;
   localparam logic [3:0]  RATE_19200     = 4'h6;
   localparam logic [3:0]  RATE_DEFAULT   = RATE_9600;
   localparam logic [5:0]  STATION_MIN    = 6'h01;
   localparam logic [5:0]  STATION_MAX    = 6'h20;
   localparam logic [1:0]  PROTO_CHAR     = 2'h0;
   localparam logic [1:0]  PROTO_BINARY   = 2'h1;
   localparam logic [1:0]  PARITY_NONE    = 2'h0;
   localparam logic [1:0]  PARITY_EVEN    = 2'h1;
   localparam logic [1:0]  PARITY_ODD     = 2'h2;
   // error actions
   localparam logic [2:0]  ACT_TRIP       = 3'h0;
   localparam logic [2:0]  ACT_DECEL_TRIP = 3'h1;
   localparam logic [2:0]  ACT_IGNORE     = 3'h2;
   localparam logic [2:0]  ACT_COAST      = 3'h3;
   localparam logic [2:0]  ACT_DECEL      = 3'h4;
   localparam logic [7:0]  TRIP_CODE_TIMEOUT = 8'h29; // value arbitrary
   localparam logic [10:0] WAIT_MS_MAX    = 11'h3E8;
   localparam logic [13:0] TIMEOUT_MAX    = 14'h270F; // units of 10 ms
   // timing: one ms and 10 ms in cycles
   localparam int          MS_NS          = 1_000_000;
   localparam int          CLK_NS         = 8;
   localparam int          MS_CYCLES      = MS_NS / CLK_NS;
   localparam int          TICK10_CYCLES  = 10 * MS_CYCLES;
   // silent interval 3.5 chars, 11 bit times each: 38.5 bits, times 2 = 77 half bits
   localparam int          SIL_HALF_BITS  = 77;
   // line rates in bits per second; bit periods follow from the clock
   localparam int          BAUD_2400      = 2400;
   localparam int          BAUD_4800      = 4800;
   localparam int          BAUD_9600      = 9600;
   localparam int          BAUD_19200     = 19200;
   typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_MONITOR, ST_ACTION} link_state_t;
endpackage

//--- rtl/cycle_timer.sv
// down counter that pulses done when a loaded count expires
`timescale 1ns/100ps
`default_nettype none
module cycle_timer #(
   parameter int W = 32
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rstn,
   // control
   input  wire logic         load,
   input  wire logic [W-1:0] count,
   input  wire logic         stop,
   // status
   output logic              running,
   output logic              done
);
   logic [W-1:0] cnt_r;
   // load wins over stop so a fresh start is never lost
   always_ff @(posedge clk) begin
      if (!rstn) begin
         cnt_r   <= '0;
         running <= 1'b0;
         done    <= 1'b0;
      end else if (load) begin
         cnt_r   <= count;
         running <= 1'b1;
         done    <= 1'b0;
      end else if (stop) begin
         running <= 1'b0;
         done    <= 1'b0;
      end else if (running && cnt_r <= W'(1)) begin
         running <= 1'b0;
         done    <= 1'b1;
      end else begin
         cnt_r   <= running ? cnt_r - W'(1) : cnt_r;
         done    <= 1'b0;
      end
   end
endmodule
`default_nettype wire

//--- rtl/loopback_test.sv
// loop-back self-test: sends a pattern frame and compares what returns
`timescale 1ns/100ps
`default_nettype none
module loopback_test #(
   parameter logic [7:0] PATTERN = 8'hA5
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // control
   input  wire logic        start,
   input  wire logic [31:0] bit_cycles,
   // line
   input  wire logic        line_rx,
   output logic             line_tx,
   // result
   output logic             busy,
   output logic             pass,
   output logic             fail
);
   // frame: start, 8 data lsb first, stop; sampled mid bit
   localparam logic [3:0] LAST_BIT = 4'h9;
   logic [31:0] cnt_r;
   logic [3:0]  idx_r;
   logic [9:0]  frame;
   logic        bad_r;
   logic        mid;
   logic        bit_end;
   assign frame   = {1'b1, PATTERN, 1'b0};
   assign mid     = (cnt_r == (bit_cycles >> 1));
   assign bit_end = (cnt_r + 32'h1 >= bit_cycles);
   // a stuck or open line shows as a mismatch on some bit
   always_ff @(posedge clk) begin
      if (!rstn) begin
         cnt_r <= '0;
         idx_r <= '0;
         bad_r <= 1'b0;
         busy  <= 1'b0;
         pass  <= 1'b0;
         fail  <= 1'b0;
         line_tx <= 1'b1;
      end else if (start && !busy) begin
         cnt_r <= '0;
         idx_r <= '0;
         bad_r <= 1'b0;
         busy  <= 1'b1;
         pass  <= 1'b0;
         fail  <= 1'b0;
         line_tx <= frame[0];
      end else if (busy) begin
         if (mid && line_rx != frame[idx_r])
            bad_r <= 1'b1;
         if (bit_end) begin
            cnt_r <= '0;
            if (idx_r == LAST_BIT) begin
               busy    <= 1'b0;
               pass    <= !bad_r;
               fail    <= bad_r;
               line_tx <= 1'b1;
            end else begin
               idx_r   <= idx_r + 4'h1;
               line_tx <= frame[idx_r + 4'h1];
            end
         end else begin
            cnt_r <= cnt_r + 32'h1;
         end
      end
   end
endmodule
`default_nettype wire

//--- rtl/rs485_link_timing_control.sv
// rs485 slave port settings, response hold-off and reception timeout control
`timescale 1ns/100ps
`default_nettype none
module rs485_link_timing_control #(
   parameter int CLK_FREQ  = link_timing_pkg::CLK_HZ,
   parameter int MS_CYC    = link_timing_pkg::MS_CYCLES,
   parameter int TICK10    = link_timing_pkg::TICK10_CYCLES
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // settings
   input  wire logic [3:0]  line_rate_code,
   input  wire logic [5:0]  station_number_setting,
   input  wire logic [3:0]  char_width_setting,
   input  wire logic [1:0]  parity_setting,
   input  wire logic [1:0]  stop_bit_setting,
   input  wire logic [2:0]  comm_error_action,
   input  wire logic [13:0] reception_timeout_setting,
   input  wire logic [10:0] response_wait_setting,
   input  wire logic [1:0]  protocol_select,
   // link events from the framer
   input  wire logic        line_activity,
   input  wire logic        query_done,
   input  wire logic        response_done,
   // loop-back line
   input  wire logic        line_rx,
   output logic             line_tx,
   // effective line format
   output logic [31:0]      bit_cycles,
   output logic [3:0]       data_bits,
   output logic [1:0]       parity_mode,
   output logic             two_stop,
   output logic [5:0]       station_id,
   output logic             binary_proto,
   // response timing
   output logic             response_go,
   output logic             query_dropped,
   // self-test result
   output logic             selftest_busy,
   output logic             selftest_pass,
   output logic             selftest_fail,
   // error actions
   output logic             comm_error,
   output logic             trip,
   output logic [7:0]       comm_timeout_trip_code,
   output logic             coast_stop,
   output logic             decel_stop
);
   // bit periods track the clock parameter, so a slow model clock keeps frames short
   localparam int BIT_2400  = CLK_FREQ / link_timing_pkg::BAUD_2400;
   localparam int BIT_4800  = CLK_FREQ / link_timing_pkg::BAUD_4800;
   localparam int BIT_9600  = CLK_FREQ / link_timing_pkg::BAUD_9600;
   localparam int BIT_19200 = CLK_FREQ / link_timing_pkg::BAUD_19200;

   // rate decode used for both bit time and silent interval
   function automatic logic [31:0] rate_bit(input logic [3:0] code);
      case (code)
         link_timing_pkg::RATE_2400:  rate_bit = 32'(BIT_2400);
         link_timing_pkg::RATE_4800:  rate_bit = 32'(BIT_4800);
         link_timing_pkg::RATE_19200: rate_bit = 32'(BIT_19200);
         default:                     rate_bit = 32'(BIT_9600);
      endcase
   endfunction

   link_timing_pkg::link_state_t state_r, state_nxt;
   logic [31:0] bit_w;
   logic [31:0] sil_w;
   logic [31:0] hold_w;
   logic [39:0] tmo_w;
   logic [31:0] gap_r;
   logic        armed_r;
   logic        arm_evt;
   logic        start_r;
   logic        st_started_r;
   logic        hold_done;
   logic        tmo_done;
   logic        hold_load;
   logic        tmo_load;
   logic        tmo_stop;
   logic        gap_ok;
   logic        tmo_en;
   logic        lb_tx;
   logic        lb_busy;
   logic        lb_pass;
   logic        lb_fail;
   logic        loop_mode;
   logic        act_trip;
   logic        act_coast;
   logic        act_decel;

   // settings decode
   assign loop_mode = (line_rate_code == link_timing_pkg::RATE_LOOPBACK);
   assign bit_w     = loop_mode ? 32'(BIT_9600) : rate_bit(line_rate_code);
   assign sil_w     = (bit_w * 32'(link_timing_pkg::SIL_HALF_BITS) + 32'h1) >> 1;
   assign hold_w    = sil_w + 32'(MS_CYC) * 32'(response_wait_setting);
   // 99.99 s at the full clock rate needs more than 32 bits
   assign tmo_w     = 40'(TICK10) * 40'(reception_timeout_setting);
   assign tmo_en    = (reception_timeout_setting != 14'h0000);
   assign gap_ok    = (gap_r >= sil_w);
   // a query counts only if the line was quiet long enough before it
   assign hold_load = query_done && gap_ok && !loop_mode;
   // the response closing the first exchange both arms and starts the monitor
   assign arm_evt   = response_done && state_r != link_timing_pkg::ST_IDLE;
   assign tmo_load  = response_done && (armed_r || arm_evt) && tmo_en;
   assign tmo_stop  = query_done || !tmo_en;
   assign act_trip  = (comm_error_action == link_timing_pkg::ACT_TRIP) ||
                      (comm_error_action == link_timing_pkg::ACT_DECEL_TRIP);
   assign act_coast = (comm_error_action == link_timing_pkg::ACT_COAST);
   assign act_decel = (comm_error_action == link_timing_pkg::ACT_DECEL) ||
                      (comm_error_action == link_timing_pkg::ACT_DECEL_TRIP);

   cycle_timer #(.W(32)) u_hold (
      .clk     (clk),
      .rstn    (rstn),
      .load    (hold_load),
      .count   (hold_w),
      .stop    (1'b0),
      .running (),
      .done    (hold_done)
   );

   cycle_timer #(.W(40)) u_tmo (
      .clk     (clk),
      .rstn    (rstn),
      .load    (tmo_load),
      .count   (tmo_w),
      .stop    (tmo_stop),
      .running (),
      .done    (tmo_done)
   );

   loopback_test u_lb (
      .clk        (clk),
      .rstn       (rstn),
      .start      (start_r),
      .bit_cycles (bit_w),
      .line_rx    (line_rx),
      .line_tx    (lb_tx),
      .busy       (lb_busy),
      .pass       (lb_pass),
      .fail       (lb_fail)
   );

   // next state: timeout leads to action, then back to waiting for data
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         link_timing_pkg::ST_IDLE:    if (hold_load) state_nxt = link_timing_pkg::ST_HOLD;
         link_timing_pkg::ST_HOLD:    if (hold_done) state_nxt = link_timing_pkg::ST_MONITOR;
         link_timing_pkg::ST_MONITOR: begin
            if (tmo_done) state_nxt = link_timing_pkg::ST_ACTION;
            else if (hold_load) state_nxt = link_timing_pkg::ST_HOLD;
         end
         link_timing_pkg::ST_ACTION:  state_nxt = link_timing_pkg::ST_IDLE;
         default:                     state_nxt = link_timing_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rstn) state_r <= link_timing_pkg::ST_IDLE;
      else       state_r <= state_nxt;
   end

   // quiet-line counter, saturates once the silent interval is met
   always_ff @(posedge clk) begin
      if (!rstn)              gap_r <= '0;
      else if (line_activity) gap_r <= '0;
      else if (!gap_ok)       gap_r <= gap_r + 32'h1;
   end

   // monitor arms only after a full query and response have completed
   always_ff @(posedge clk) begin
      if (!rstn)                                            armed_r <= 1'b0;
      else if (arm_evt)                                     armed_r <= 1'b1;
   end

   // self-test fires once after reset when the loop-back code is set
   always_ff @(posedge clk) begin
      if (!rstn) begin
         start_r      <= 1'b0;
         st_started_r <= 1'b0;
      end else begin
         start_r      <= loop_mode && !st_started_r;
         st_started_r <= st_started_r || loop_mode;
      end
   end

   // registered format and timing outputs
   always_ff @(posedge clk) begin
      if (!rstn) begin
         bit_cycles    <= 32'(BIT_9600);
         data_bits     <= 4'h8;
         parity_mode   <= link_timing_pkg::PARITY_NONE;
         two_stop      <= 1'b0;
         station_id    <= link_timing_pkg::STATION_MIN;
         binary_proto  <= 1'b1;
         response_go   <= 1'b0;
         query_dropped <= 1'b0;
         line_tx       <= 1'b1;
      end else begin
         bit_cycles    <= bit_w;
         // binary protocol always runs 8 data bits
         data_bits     <= (protocol_select != link_timing_pkg::PROTO_CHAR ||
                           char_width_setting != 4'h7) ? 4'h8 : 4'h7;
         parity_mode   <= (parity_setting > link_timing_pkg::PARITY_ODD) ?
                          link_timing_pkg::PARITY_NONE : parity_setting;
         two_stop      <= (stop_bit_setting == 2'h2);
         // out-of-range station falls back to the default
         station_id    <= (station_number_setting < link_timing_pkg::STATION_MIN ||
                           station_number_setting > link_timing_pkg::STATION_MAX) ?
                          link_timing_pkg::STATION_MIN : station_number_setting;
         binary_proto  <= (protocol_select != link_timing_pkg::PROTO_CHAR);
         response_go   <= hold_done && state_r == link_timing_pkg::ST_HOLD;
         query_dropped <= query_done && !gap_ok;
         line_tx       <= lb_tx;
      end
   end

   // self-test result and error actions; actions latch until reset
   always_ff @(posedge clk) begin
      if (!rstn) begin
         selftest_busy <= 1'b0;
         selftest_pass <= 1'b0;
         selftest_fail <= 1'b0;
         comm_error    <= 1'b0;
         trip          <= 1'b0;
         comm_timeout_trip_code <= 8'h00;
         coast_stop    <= 1'b0;
         decel_stop    <= 1'b0;
      end else begin
         selftest_busy <= lb_busy;
         selftest_pass <= selftest_pass || lb_pass;
         selftest_fail <= selftest_fail || lb_fail;
         comm_error    <= (state_r == link_timing_pkg::ST_ACTION);
         if (state_r == link_timing_pkg::ST_ACTION) begin
            trip       <= trip || act_trip;
            coast_stop <= coast_stop || act_coast;
            decel_stop <= decel_stop || act_decel;
            if (act_trip)
               comm_timeout_trip_code <= link_timing_pkg::TRIP_CODE_TIMEOUT;
         end
      end
   end

   // assertions
   sequence s_timeout;
      state_r == link_timing_pkg::ST_ACTION;
   endsequence

   property p_no_trip_soft;
      @(posedge clk) disable iff (!rstn)
      (s_timeout and comm_error_action == link_timing_pkg::ACT_IGNORE && !trip) |=> !trip;
   endproperty
   a_no_trip_soft: assert property (p_no_trip_soft) else $error("soft action tripped");

   property p_trip_hard;
      @(posedge clk) disable iff (!rstn)
      (s_timeout and comm_error_action == link_timing_pkg::ACT_TRIP) |=> trip && comm_error;
   endproperty
   a_trip_hard: assert property (p_trip_hard) else $error("trip missing");

   property p_action_returns;
      @(posedge clk) disable iff (!rstn)
      s_timeout |=> state_r == link_timing_pkg::ST_IDLE;
   endproperty
   a_action_returns: assert property (p_action_returns) else $error("no return to idle");

   property p_unarmed_quiet;
      @(posedge clk) disable iff (!rstn)
      !armed_r |-> state_r != link_timing_pkg::ST_ACTION;
   endproperty
   a_unarmed_quiet: assert property (p_unarmed_quiet) else $error("timeout before exchange");

   property p_drop_short;
      @(posedge clk) disable iff (!rstn)
      (query_done && !gap_ok) |=> query_dropped && !response_go;
   endproperty
   a_drop_short: assert property (p_drop_short) else $error("short gap answered");

   property p_go_from_hold;
      @(posedge clk) disable iff (!rstn)
      response_go |-> $past(state_r) == link_timing_pkg::ST_HOLD;
   endproperty
   a_go_from_hold: assert property (p_go_from_hold) else $error("response outside hold");

   property p_width_binary;
      @(posedge clk) disable iff (!rstn)
      protocol_select == link_timing_pkg::PROTO_BINARY |=> data_bits == 4'h8;
   endproperty
   a_width_binary: assert property (p_width_binary) else $error("binary width not 8");

   property p_station_range;
      @(posedge clk) disable iff (!rstn)
      station_id >= link_timing_pkg::STATION_MIN && station_id <= link_timing_pkg::STATION_MAX;
   endproperty
   a_station_range: assert property (p_station_range) else $error("station out of range");

   property p_disabled_tmo;
      @(posedge clk) disable iff (!rstn)
      (reception_timeout_setting == 14'h0000)[*2] |-> !tmo_done;
   endproperty
   a_disabled_tmo: assert property (p_disabled_tmo) else $error("timeout while disabled");
endmodule
`default_nettype wire

//--- verif/link_master_model.sv
// behavioural bus master on the far side of the rs485 link timing block
`timescale 1ns/100ps
`default_nettype none
module link_master_model (
   // clock and reset
   input  wire logic clk,
   input  wire logic rstn,
   // commands from the bench
   input  wire logic q_req,
   input  wire logic q_short,
   input  wire logic r_req,
   input  wire logic loop_bad,
   // framer events towards the block
   output logic      line_activity = 1'b0,
   output logic      query_done = 1'b0,
   output logic      response_done = 1'b0,
   // line
   input  wire logic line_tx,
   output logic      line_rx
);
   int q_cnt;
   // short query: a burst of line activity, then the query end a few cycles later
   always @(posedge clk) begin
      line_activity <= 1'b0;
      query_done    <= 1'b0;
      response_done <= r_req;
      if (!rstn) begin
         q_cnt <= 0;
      end else if (q_req && q_short) begin
         line_activity <= 1'b1;
         q_cnt         <= 6;
      end else if (q_req) begin
         query_done <= 1'b1;
      end else if (q_cnt > 0) begin
         q_cnt      <= q_cnt - 1;
         query_done <= (q_cnt == 1);
      end
   end
   // cable off the terminals: tx loops to rx, inverted when a broken line is wanted
   assign line_rx = loop_bad ? ~line_tx : line_tx;
endmodule
`default_nettype wire

//--- verif/tb.sv
// self-checking bench for the rs485 link timing control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
   $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module tb;
   localparam int MS_CYC = 10;
   localparam int TICK10 = 100;
   localparam int CLK_FREQ = 960_000;
   // stimulus
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic [3:0]  line_rate_code = 4'h5;
   logic [5:0]  station_number_setting = 6'h01;
   logic [3:0]  char_width_setting = 4'h8;
   logic [1:0]  parity_setting = 2'h0;
   logic [1:0]  stop_bit_setting = 2'h1;
   logic [2:0]  comm_error_action = 3'h2;
   logic [13:0] reception_timeout_setting = 14'h0000;
   logic [10:0] response_wait_setting = 11'h000;
   logic [1:0]  protocol_select = 2'h1;
   logic        q_req = 1'b0, q_short = 1'b0, r_req = 1'b0, loop_bad = 1'b0;
   // observed
   logic        line_activity, query_done, response_done, line_rx, line_tx;
   logic [31:0] bit_cycles;
   logic [3:0]  data_bits;
   logic [1:0]  parity_mode;
   logic [5:0]  station_id;
   logic        two_stop, binary_proto, response_go, query_dropped, selftest_busy;
   logic        selftest_pass, selftest_fail, comm_error, trip, coast_stop, decel_stop;
   logic [7:0]  comm_timeout_trip_code;
   int          n_fail = 0, comparisons = 0, cyc = 0, err_cnt = 0, go_cnt = 0, drop_cnt = 0;
   logic [3:0]  rates [6] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h0, 4'hF};
   logic [5:0]  stns [6] = '{6'h00, 6'h01, 6'h20, 6'h21, 6'h3F, 6'h10};

   rs485_link_timing_control #(.CLK_FREQ(CLK_FREQ), .MS_CYC(MS_CYC), .TICK10(TICK10)) dut_u (
      .clk, .rstn, .line_rate_code, .station_number_setting, .char_width_setting,
      .parity_setting, .stop_bit_setting, .comm_error_action, .reception_timeout_setting,
      .response_wait_setting, .protocol_select, .line_activity, .query_done, .response_done,
      .line_rx, .line_tx, .bit_cycles, .data_bits, .parity_mode, .two_stop, .station_id,
      .binary_proto, .response_go, .query_dropped, .selftest_busy, .selftest_pass,
      .selftest_fail, .comm_error, .trip, .comm_timeout_trip_code, .coast_stop, .decel_stop);
   link_master_model master_u (
      .clk, .rstn, .q_req, .q_short, .r_req, .loop_bad, .line_activity, .query_done,
      .response_done, .line_tx, .line_rx);

   always #4 clk = ~clk;
   // event counters; the cycle ceiling covers eight exchanges and two self-tests
   always @(posedge clk) begin
      cyc++;
      if (comm_error === 1'b1) err_cnt++;
      if (response_go === 1'b1) go_cnt++;
      if (query_dropped === 1'b1) drop_cnt++;
      if (cyc == 60_000) begin
         n_fail++;
         final_report();
      end
   end

   function automatic int bit_of(input logic [3:0] r);
      case (r)
         link_timing_pkg::RATE_2400:  return CLK_FREQ / link_timing_pkg::BAUD_2400;
         link_timing_pkg::RATE_4800:  return CLK_FREQ / link_timing_pkg::BAUD_4800;
         link_timing_pkg::RATE_19200: return CLK_FREQ / link_timing_pkg::BAUD_19200;
         default:                     return CLK_FREQ / link_timing_pkg::BAUD_9600;
      endcase
   endfunction
   // 3.5 characters as half bits, rounded up
   function automatic int sil_of(input logic [3:0] r);
      return (bit_of(r) * link_timing_pkg::SIL_HALF_BITS + 1) / 2;
   endfunction

   task automatic step(input int n);
      repeat (n) begin
         @(posedge clk);
         #1;
      end
   endtask
   task automatic do_reset();
      rstn = 1'b0;
      step(10);
      rstn = 1'b1;
   endtask
   task automatic pulse_q(input logic s);
      q_short = s;
      q_req = 1'b1;
      step(1);
      q_req = 1'b0;
   endtask
   task automatic pulse_r();
      r_req = 1'b1;
      step(1);
      r_req = 1'b0;
   endtask
   task automatic fmt_check(input logic [3:0] r, input logic [5:0] st, input logic [3:0] w,
                            input logic [1:0] par, input logic [1:0] stp, input logic [1:0] pro);
      line_rate_code = (r == link_timing_pkg::RATE_LOOPBACK) ? 4'h6 : r;
      station_number_setting = st;
      char_width_setting = w;
      parity_setting = par;
      stop_bit_setting = stp;
      protocol_select = pro;
      step(3);
      `CHK("bit_cycles", 32'(bit_of(line_rate_code)), bit_cycles)
      `CHK("station_id", (st >= 6'h01 && st <= 6'h20) ? st : 6'h01, station_id)
      `CHK("data_bits", (pro == 2'h0 && w == 4'h7) ? 4'h7 : 4'h8, data_bits)
      `CHK("binary_proto", pro != 2'h0, binary_proto)
      `CHK("parity_mode", (par == 2'h3) ? 2'h0 : par, parity_mode)
      `CHK("two_stop", stp == 2'h2, two_stop)
   endtask
   // quiet gap, one accepted query, response hold measured to response_go
   task automatic exchange(input logic [10:0] w);
      int n, g0, hold;
      response_wait_setting = w;
      hold = sil_of(line_rate_code) + int'(w) * MS_CYC;
      step(sil_of(line_rate_code) + 20);
      g0 = go_cnt;
      pulse_q(1'b0);
      n = 1;
      while (go_cnt == g0 && n < hold + 40) begin
         step(1);
         n++;
      end
      `CHK("hold_cycles_ok", 1'b1, n >= hold && n <= hold + 10)
   endtask
   // a response goes out, nothing returns, the timeout fires and the action latches
   task automatic tmo_case(input logic [2:0] act, input logic t, input logic c, input logic d);
      int n, e0;
      comm_error_action = act;
      // a response only follows an accepted query
      exchange(11'h001);
      e0 = err_cnt;
      pulse_r();
      n = 1;
      while (err_cnt == e0 && n < 400) begin
         step(1);
         n++;
      end
      `CHK("tmo_cycles_ok", 1'b1, n >= 2 * TICK10 && n <= 2 * TICK10 + 10)
      step(3);
      `CHK("comm_error_pulses", e0 + 1, err_cnt)
      `CHK("trip", t, trip)
      `CHK("coast_stop", c, coast_stop)
      `CHK("decel_stop", d, decel_stop)
      `CHK("trip_code", t ? link_timing_pkg::TRIP_CODE_TIMEOUT : 8'h00, comm_timeout_trip_code)
   endtask
   task automatic lb_case(input logic bad);
      int n;
      loop_bad = bad;
      do_reset();
      step(100);
      `CHK("st_busy_run", 1'b1, selftest_busy)
      n = 100;
      while (selftest_pass !== 1'b1 && selftest_fail !== 1'b1 && n < 20000) begin
         step(1);
         n++;
      end
      `CHK("st_frame_ok", 1'b1, n >= 8 * bit_of(link_timing_pkg::RATE_9600))
      `CHK("st_pass", !bad, selftest_pass)
      `CHK("st_fail", bad, selftest_fail)
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // main sequence: defaults, formats, response timing, timeouts, self-test
   initial begin
      int e0, d0, g0;
      void'($urandom(43309));
      step(10);
      `CHK("rst_bit_cycles", 32'(bit_of(link_timing_pkg::RATE_9600)), bit_cycles)
      `CHK("rst_station", 6'h01, station_id)
      `CHK("rst_binary", 1'b1, binary_proto)
      `CHK("rst_bits", 4'h8, data_bits)
      rstn = 1'b1;
      step(1);
      for (int i = 0; i < 24; i++) begin
         if (i < 6) fmt_check(rates[i], stns[i], 4'h7, 2'(i), 2'(i), 2'(i % 2));
         else fmt_check(4'($urandom_range(0, 15)), 6'($urandom), 4'($urandom_range(6, 9)),
                        2'($urandom), 2'($urandom), 2'($urandom));
      end
      line_rate_code = link_timing_pkg::RATE_19200;
      reception_timeout_setting = 14'h0001;
      comm_error_action = link_timing_pkg::ACT_TRIP;
      d0 = drop_cnt;
      g0 = go_cnt;
      pulse_q(1'b1);
      step(12);
      `CHK("dropped", d0 + 1, drop_cnt)
      pulse_r();
      step(400);
      `CHK("no_response", g0, go_cnt)
      `CHK("early_timeout", 0, err_cnt)
      `CHK("early_trip", 1'b0, trip)
      reception_timeout_setting = 14'h0002;
      exchange(11'h005);
      tmo_case(link_timing_pkg::ACT_IGNORE, 1'b0, 1'b0, 1'b0);
      tmo_case(link_timing_pkg::ACT_COAST, 1'b0, 1'b1, 1'b0);
      tmo_case(link_timing_pkg::ACT_TRIP, 1'b1, 1'b1, 1'b0);
      do_reset();
      exchange(11'h000);
      tmo_case(link_timing_pkg::ACT_DECEL, 1'b0, 1'b0, 1'b1);
      tmo_case(link_timing_pkg::ACT_DECEL_TRIP, 1'b1, 1'b0, 1'b1);
      reception_timeout_setting = 14'h0000;
      // monitor state and armed, so a running timer would show here
      exchange(11'h000);
      e0 = err_cnt;
      pulse_r();
      step(400);
      `CHK("disabled_timeout", e0, err_cnt)
      reception_timeout_setting = 14'h0002;
      pulse_r();
      step(50);
      pulse_q(1'b0);
      step(400);
      `CHK("query_stops_timer", e0, err_cnt)
      line_rate_code = link_timing_pkg::RATE_LOOPBACK;
      lb_case(1'b0);
      lb_case(1'b1);
      final_report();
   end
endmodule
`default_nettype wire
